// ==== shared/epr_defines.vh ====
`ifndef EPR_DEFINES_VH
`define EPR_DEFINES_VH
// register indexes within the 32-register management space (byte address = 4 * index)
`define EPR_IDX_SM_CTRL 5'h10
`define EPR_IDX_SWING 5'h11
`define EPR_IDX_CRC_CNT 5'h12
`define EPR_IDX_SD_POL 5'h13
`define EPR_IDX_PAGE 5'h1F
`define EPR_IDX_STD_LAST 5'h0F
// page select values
`define EPR_PAGE_MAIN 16'h0000
`define EPR_PAGE_EXT 16'h0001
`define EPR_PAGE_GPIO 16'h0010
// field positions
`define EPR_SM_TXRF_HI 15
`define EPR_SM_TXRF_LO 14
`define EPR_SM_LPRF_HI 13
`define EPR_SM_LPRF_LO 12
`define EPR_SM_PDET 11
`define EPR_SM_SIGNAL_DETECT_PIN 10
`define EPR_SW_MEDIA_HI 7
`define EPR_SW_MEDIA_LO 5
`define EPR_SW_MAC_HI 4
`define EPR_SW_MAC_LO 2
`define EPR_CNT_PKT 15
`define EPR_CNT_HI 13
`define EPR_POL_BIT 0
// reset values and largest legal swing code
`define EPR_RST_PAGE 16'h0000
`define EPR_RST_TXRF 2'h0
`define EPR_RST_PDET 1'h0
`define EPR_RST_MEDIA_SW 3'h0
`define EPR_RST_MAC_SW 3'h4
`define EPR_RST_POL 1'h0
`define EPR_SW_MAX 3'h5
`endif

// ==== src/epr_std_mem.v ====
`timescale 1ns/100ps
`include "epr_defines.vh"

// ------------------------------------------------------------
// small word memory standing for a register space outside this block
// ------------------------------------------------------------
module epr_std_mem #(
  parameter AW = 5,
  parameter DW = 16
) (
  input wire sys_clk_in, // system clock
  input wire wr_en_in, // write strobe
  input wire [AW-1:0] addr_in, // word address
  input wire [DW-1:0] wdata_in, // write data
  output reg [DW-1:0] rdata_out // registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // synchronous write, registered read
  always @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule

// ==== src/epr_page_regs.v ====
`timescale 1ns/100ps
`include "epr_defines.vh"

// How it works
// R1: page register value 0x0001 selects the extended page.
// R2: with extended page, addresses 16..30 reach extended registers.
// R3: addresses 0..15 reach standard registers unless page value 0x0010 sends them to the GPIO space.
// R4: writing 0x0000 returns to main space; page resets to 0x0000.
// R5: page value 0x0010 sends addresses 0..30 to the GPIO space.
// R6: transmit remote fault field bits 15:14 goes to link partner; default 00.
// R7: link partner remote fault captured into read-only bits 13:12.
// R8: bit 11 enables parallel detect; default 0.
// R9: serial media signal detect shown on read-only bit 10.
// R10: media swing 7:5 and MAC swing 4:2, codes 0..5; MAC default 100.
// R11: bit 15 set when packet received since last read; read clears.
// R12: 14-bit good CRC count, clears on read, wraps, never saturates.
// R13: polarity bit 0: 1 means pin active low, 0 active high.
// R14: sticky fields survive software reset; only hardware reset clears.
// R15: reserved bits read zero; writes to them ignored.
module epr_page_regs (
  input wire sys_clk_in, // 250 MHz clock
  input wire reset_n_in, // async hardware reset, active low
  input wire soft_reset_in, // software reset pulse, same clock
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [31:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready
  output wire [31:0] prdata, // apb read data
  output wire pslverr, // apb error
  input wire [1:0] lp_remote_fault_in, // partner fault bits from negotiation
  input wire lp_fault_valid_in, // partner fault bits valid strobe
  input wire signal_detect_pin_in, // raw signal detect pin
  input wire good_crc_pkt_in, // one pulse per good-crc packet
  output reg [1:0] tx_remote_fault_out, // fault bits to advertise
  output reg parallel_detect_en_out, // parallel detect enable
  output reg [2:0] media_swing_out, // media output swing code
  output reg [2:0] mac_swing_out, // mac output swing code
  output reg signal_detect_out // signal detect, polarity applied
);
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] page_q;
  reg [1:0] txrf_q;
  reg pdet_q;
  reg [2:0] media_sw_q;
  reg [2:0] mac_sw_q;
  reg pol_q;
  reg [1:0] lprf_q;
  reg pkt_q;
  reg [13:0] cnt_q;
  reg sd_meta_q;
  reg sd_sync_q;
  reg [15:0] rdata_q;
  reg [15:0] ext_rd;
  wire [4:0] idx;
  wire access;
  wire in_ext;
  wire in_std;
  wire std_wr;
  wire [15:0] std_rd;
  wire [15:0] gpio_rd;
  wire rd_cnt;
  wire ext_commit;

  // space selection for one register index
  // page values other than extended and gpio leave the main space in use
  function sel_ext;
    input [4:0] a;
    input [15:0] pg;
    begin
      sel_ext = (pg == `EPR_PAGE_EXT) && (a > `EPR_IDX_STD_LAST) && (a != `EPR_IDX_PAGE); // see R1 R2
    end
  endfunction

  function sel_gpio;
    input [4:0] a;
    input [15:0] pg;
    begin
      sel_gpio = (pg == `EPR_PAGE_GPIO) && (a != `EPR_IDX_PAGE); // see R5
    end
  endfunction

  // clamp reserved swing codes to the largest legal code
  function [2:0] clamp_sw;
    input [2:0] c;
    begin
      clamp_sw = (c > `EPR_SW_MAX) ? `EPR_SW_MAX : c; // see R10
    end
  endfunction

  // write strobe of one extended register, only in the committing cycle
  function ext_wr;
    input [4:0] a;
    input [4:0] target;
    input hit;
    begin
      ext_wr = hit && (a == target);
    end
  endfunction

  assign idx = paddr[6:2];
  assign access = psel && penable && (state_q == ST_DONE);
  assign in_ext = sel_ext(idx, page_q);
  assign in_std = !in_ext && !sel_gpio(idx, page_q) && (idx != `EPR_IDX_PAGE); // see R3 R4
  assign std_wr = access && pwrite && in_std;
  // counter clears at the edge that captures its read value, so a packet
  // arriving between capture and ready is counted afresh instead of lost
  assign rd_cnt = (state_q == ST_WAIT) && psel && !pwrite && in_ext
    && (idx == `EPR_IDX_CRC_CNT); // see R12
  assign ext_commit = access && pwrite && in_ext;
  assign pready = (state_q == ST_DONE);
  assign pslverr = 1'b0;
  assign prdata = {16'h0000, rdata_q};

  // ------------------------------------------------------------
  // memories standing for standard and gpio spaces
  // ------------------------------------------------------------
  epr_std_mem #(.AW(5), .DW(16)) u_std (
    .sys_clk_in(sys_clk_in),
    .wr_en_in(std_wr),
    .addr_in(idx),
    .wdata_in(pwdata[15:0]),
    .rdata_out(std_rd)
  );

  epr_std_mem #(.AW(5), .DW(16)) u_gpio (
    .sys_clk_in(sys_clk_in),
    .wr_en_in(access && pwrite && sel_gpio(idx, page_q)),
    .addr_in(idx),
    .wdata_in(pwdata[15:0]),
    .rdata_out(gpio_rd)
  );

  // three-step access once enable is seen in idle: idle, wait for memory read, done
  // the wait state lets the registered memory read settle before ready
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (psel && penable) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        state_d = ST_DONE;
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // extended register read mux, reserved bits zero
  always @* begin
    ext_rd = 16'h0000; // see R15
    case (idx)
      `EPR_IDX_SM_CTRL: begin
        ext_rd[`EPR_SM_TXRF_HI:`EPR_SM_TXRF_LO] = txrf_q;
        ext_rd[`EPR_SM_LPRF_HI:`EPR_SM_LPRF_LO] = lprf_q; // see R7
        ext_rd[`EPR_SM_PDET] = pdet_q;
        ext_rd[`EPR_SM_SIGNAL_DETECT_PIN] = signal_detect_out; // see R9
      end
      `EPR_IDX_SWING: begin
        ext_rd[`EPR_SW_MEDIA_HI:`EPR_SW_MEDIA_LO] = media_sw_q;
        ext_rd[`EPR_SW_MAC_HI:`EPR_SW_MAC_LO] = mac_sw_q;
      end
      `EPR_IDX_CRC_CNT: begin
        ext_rd[`EPR_CNT_PKT] = pkt_q; // see R11
        ext_rd[`EPR_CNT_HI:0] = cnt_q; // see R12
      end
      `EPR_IDX_SD_POL: begin
        ext_rd[`EPR_POL_BIT] = pol_q;
      end
      default: begin
        ext_rd = 16'h0000;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state, page select and read data
  // ------------------------------------------------------------
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      page_q <= `EPR_RST_PAGE; // see R4
      rdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (soft_reset_in) begin
        page_q <= `EPR_RST_PAGE;
      end else if (access && pwrite && idx == `EPR_IDX_PAGE) begin
        page_q <= pwdata[15:0]; // see R1 R4 R5
      end
      if (state_q == ST_WAIT) begin
        if (idx == `EPR_IDX_PAGE) begin
          rdata_q <= page_q;
        end else if (in_ext) begin
          rdata_q <= ext_rd;
        end else if (sel_gpio(idx, page_q)) begin
          rdata_q <= gpio_rd;
        end else begin
          rdata_q <= std_rd; // see R3
        end
      end
    end
  end

  // ------------------------------------------------------------
  // extended registers
  // ------------------------------------------------------------
  // non-sticky control fields: cleared by hardware or software reset
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      txrf_q <= `EPR_RST_TXRF;
      pdet_q <= `EPR_RST_PDET;
      lprf_q <= 2'h0;
    end else if (soft_reset_in) begin
      txrf_q <= `EPR_RST_TXRF;
      pdet_q <= `EPR_RST_PDET;
      lprf_q <= 2'h0;
    end else begin
      if (ext_wr(idx, `EPR_IDX_SM_CTRL, ext_commit)) begin
        txrf_q <= pwdata[`EPR_SM_TXRF_HI:`EPR_SM_TXRF_LO]; // see R6
        pdet_q <= pwdata[`EPR_SM_PDET]; // see R8
      end
      if (lp_fault_valid_in) begin
        lprf_q <= lp_remote_fault_in; // see R7
      end
    end
  end

  // sticky fields: only hardware reset returns them to defaults
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      media_sw_q <= `EPR_RST_MEDIA_SW; // see R14
      mac_sw_q <= `EPR_RST_MAC_SW; // see R10
      pol_q <= `EPR_RST_POL;
    end else begin
      if (ext_wr(idx, `EPR_IDX_SWING, ext_commit)) begin
        media_sw_q <= pwdata[`EPR_SW_MEDIA_HI:`EPR_SW_MEDIA_LO];
        mac_sw_q <= pwdata[`EPR_SW_MAC_HI:`EPR_SW_MAC_LO];
      end
      if (ext_wr(idx, `EPR_IDX_SD_POL, ext_commit)) begin
        pol_q <= pwdata[`EPR_POL_BIT]; // see R13
      end
    end
  end

  // good-crc counter; a packet in the clearing cycle is kept
  // clearing happens with the read capture, one edge before ready
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pkt_q <= 1'b0;
      cnt_q <= 14'h0000;
    end else if (soft_reset_in) begin
      pkt_q <= 1'b0;
      cnt_q <= 14'h0000;
    end else if (rd_cnt) begin
      pkt_q <= good_crc_pkt_in; // see R11
      cnt_q <= good_crc_pkt_in ? 14'h0001 : 14'h0000; // see R12
    end else if (good_crc_pkt_in) begin
      pkt_q <= 1'b1;
      cnt_q <= cnt_q + 14'h0001; // see R12
    end
  end

  // signal detect pin synchroniser, then polarity
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sd_meta_q <= 1'b0;
      sd_sync_q <= 1'b0;
      signal_detect_out <= 1'b0;
    end else begin
      sd_meta_q <= signal_detect_pin_in;
      sd_sync_q <= sd_meta_q;
      signal_detect_out <= sd_sync_q ^ pol_q; // see R13
    end
  end

  // registered control outputs
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_remote_fault_out <= `EPR_RST_TXRF;
      parallel_detect_en_out <= `EPR_RST_PDET;
      media_swing_out <= `EPR_RST_MEDIA_SW;
      mac_swing_out <= `EPR_RST_MAC_SW;
    end else begin
      tx_remote_fault_out <= txrf_q; // see R6
      parallel_detect_en_out <= pdet_q; // see R8
      media_swing_out <= clamp_sw(media_sw_q);
      mac_swing_out <= clamp_sw(mac_sw_q);
    end
  end
endmodule

// ==== tb/epr_page_regs_chk.sv ====
`timescale 1ns/100ps
`include "epr_defines.vh"
// ----
// bus and output checks
// ----
module epr_page_regs_chk (
  input wire sys_clk_in, // clock
  input wire reset_n_in, // reset, active low
  input wire soft_reset_in, // soft reset
  input wire psel, // select
  input wire penable, // enable
  input wire pwrite, // direction
  input wire pready, // ready
  input wire [31:0] prdata, // read data
  input wire pslverr, // error
  input wire signal_detect_pin_in, // raw pin
  input wire [1:0] tx_remote_fault_out, // fault bits
  input wire parallel_detect_en_out, // parallel detect
  input wire [2:0] media_swing_out, // media swing
  input wire [2:0] mac_swing_out, // mac swing
  input wire signal_detect_out // detect
);
  // one domain, hardware reset stops every check
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  reset_vals_a: assert property (
    $rose(reset_n_in) |-> mac_swing_out == `EPR_RST_MAC_SW && media_swing_out == 3'h0
    && tx_remote_fault_out == 2'h0 && !parallel_detect_en_out)
    else $error("outputs not at reset values");
  swing_clamp_a: assert property (
    mac_swing_out <= `EPR_SW_MAX && media_swing_out <= `EPR_SW_MAX)
    else $error("swing output above top code");
  signal_detect_pin_hold_a: assert property (
    (!psel && $stable(signal_detect_pin_in)) [*6] |-> $stable(signal_detect_out))
    else $error("detect output moved with quiet pin");
  ready_delay_a: assert property (
    psel && penable && !$past(penable) |-> !pready ##1 !pready ##1 pready)
    else $error("ready not two cycles after access");
  ready_pulse_a: assert property (
    pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or too long");
  upper_zero_a: assert property (
    pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  no_error_a: assert property (
    pready |-> !pslverr)
    else $error("error response given");
  sticky_soft_a: assert property (
    soft_reset_in && !pready && !$past(pready) |=> $stable(media_swing_out)
    && $stable(mac_swing_out))
    else $error("swing changed by soft reset");
  soft_clear_a: assert property (
    soft_reset_in && !pready ##1 !pready |=> tx_remote_fault_out == 2'h0
    && !parallel_detect_en_out)
    else $error("soft reset left fault or detect set");
endmodule

bind epr_page_regs epr_page_regs_chk chk_u (.*);

// ==== tb/epr_mgmt_host.sv ====
`timescale 1ns/100ps
// ----
// management controller on the register bus
// ----
module epr_mgmt_host (
  input wire logic sys_clk_in, // bus clock
  input wire logic pready, // slave ready
  input wire logic [31:0] prdata, // slave read data
  output logic psel = 1'b0, // select
  output logic penable = 1'b0, // access phase
  output logic pwrite = 1'b0, // direction
  output logic [31:0] paddr = 32'h0, // byte address
  output logic [31:0] pwdata = 32'h0 // write data
);
  logic hung = 1'b0;
  // setup, then hold the access until ready is sampled high or 64 cycles pass
  task automatic xfer(input logic w, input logic [4:0] idx, input logic [15:0] wd,
    output logic [15:0] rdat);
    int n;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {25'h0, idx, 2'h0};
    pwdata <= {16'h0, wd};
    @(posedge sys_clk_in);
    penable <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk_in);
      if (pready === 1'b1) break;
    end
    hung = (n == 64);
    rdat = prdata[15:0];
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr; // released lines do not keep the last value
    pwdata <= ~pwdata;
  endtask
endmodule

// ==== tb/extended_page_register_map_test.sv ====
`timescale 1ns/100ps
`include "epr_defines.vh"
// ----
// register bank bench
// ----
module extended_page_register_map_test;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic soft_reset_in = 1'b0;
  logic [1:0] lp_rf = 2'h0;
  logic lp_v = 1'b0;
  logic pin = 1'b0;
  logic pkt = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, pd, sd;
  wire [31:0] paddr, pwdata, prdata;
  wire [1:0] tx;
  wire [2:0] media, mac;
  logic [15:0] v, r, sv;
  logic [1:0] k;
  int n;
  int miscompares = 0;
  int checked = 0;
  // 250 MHz clock
  always #2 sys_clk_in = ~sys_clk_in;
  epr_mgmt_host host_u (.sys_clk_in(sys_clk_in), .pready(pready), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  epr_page_regs dut_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .soft_reset_in(soft_reset_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .lp_remote_fault_in(lp_rf), .lp_fault_valid_in(lp_v), .signal_detect_pin_in(pin),
    .good_crc_pkt_in(pkt), .tx_remote_fault_out(tx), .parallel_detect_en_out(pd),
    .media_swing_out(media), .mac_swing_out(mac), .signal_detect_out(sd));
  function automatic logic [2:0] clamp(input logic [2:0] c);
    return (c > `EPR_SW_MAX) ? `EPR_SW_MAX : c;
  endfunction
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic go(input logic w, input logic [4:0] a, input logic [15:0] d);
    host_u.xfer(w, a, d, r);
    if (host_u.hung) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic pulses(input int cnt);
    repeat (cnt) begin
      @(posedge sys_clk_in);
      pkt <= 1'b1;
      @(posedge sys_clk_in);
      pkt <= 1'b0;
    end
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h08668CEE));
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    @(negedge sys_clk_in);
    cmp({tx, pd, media, mac}, {6'h0, `EPR_RST_MAC_SW});
    go(0, `EPR_IDX_PAGE, 0);
    cmp(r, `EPR_RST_PAGE);
    go(1, `EPR_IDX_PAGE, `EPR_PAGE_EXT);
    v = $urandom;
    go(1, `EPR_IDX_SM_CTRL, v);
    go(0, `EPR_IDX_SM_CTRL, 0);
    cmp(r, v & 16'hC800);
    cmp({tx, pd}, {v[15:14], v[11]});
    for (int c = 0; c < 8; c++) begin
      v = $urandom;
      v[7:5] = c[2:0];
      v[4:2] = 3'h7 - c[2:0];
      go(1, `EPR_IDX_SWING, v);
      go(0, `EPR_IDX_SWING, 0);
      cmp(r, v & 16'h00FC);
      cmp({media, mac}, {clamp(v[7:5]), clamp(v[4:2])});
    end
    sv = v;
    k = 2'($urandom);
    @(posedge sys_clk_in);
    lp_rf <= k;
    lp_v <= 1'b1;
    @(posedge sys_clk_in);
    lp_v <= 1'b0;
    lp_rf <= ~k;
    go(0, `EPR_IDX_SM_CTRL, 0);
    cmp(r[13:12], k);
    v = $urandom | 1;
    go(1, `EPR_IDX_SD_POL, v);
    go(0, `EPR_IDX_SD_POL, 0);
    cmp(r, 16'h0001);
    cmp(sd, 1'b1);
    go(0, `EPR_IDX_SM_CTRL, 0);
    cmp(r[10], 1'b1);
    pin <= 1'b1;
    repeat (6) @(negedge sys_clk_in);
    cmp(sd, 1'b0);
    go(0, `EPR_IDX_CRC_CNT, 0);
    for (int w = 0; w < 2; w++) begin
      n = w * 16384 + 1 + $urandom % 20;
      pulses(n);
      go(0, `EPR_IDX_CRC_CNT, 0);
      cmp(r, 16'h8000 | n[13:0]);
      go(0, `EPR_IDX_CRC_CNT, 0);
      cmp(r, 16'h0000);
    end
    fork
      go(0, `EPR_IDX_CRC_CNT, 0);
      pulses(3);
    join
    v = r;
    go(0, `EPR_IDX_CRC_CNT, 0);
    cmp(v[13:0] + r[13:0], 14'h0003);
    go(1, `EPR_IDX_PAGE, `EPR_PAGE_MAIN);
    go(1, `EPR_IDX_SWING, 16'hFFFF);
    go(0, `EPR_IDX_SWING, 0);
    cmp(r, 16'hFFFF);
    go(1, 5'h05, 16'h1234);
    go(1, `EPR_IDX_PAGE, `EPR_PAGE_EXT);
    go(0, `EPR_IDX_SWING, 0);
    cmp(r, sv & 16'h00FC);
    go(0, 5'h05, 0);
    cmp(r, 16'h1234);
    go(1, `EPR_IDX_PAGE, `EPR_PAGE_GPIO);
    go(1, 5'h05, 16'h00C3);
    go(0, 5'h05, 0);
    cmp(r, 16'h00C3);
    go(1, `EPR_IDX_PAGE, `EPR_PAGE_MAIN);
    go(0, 5'h05, 0);
    cmp(r, 16'h1234);
    go(1, `EPR_IDX_PAGE, `EPR_PAGE_EXT);
    go(1, `EPR_IDX_SM_CTRL, 16'hC800);
    go(0, `EPR_IDX_SM_CTRL, 0);
    cmp(r & 16'hC800, 16'hC800);
    cmp({tx, pd}, 3'h7);
    @(posedge sys_clk_in);
    soft_reset_in <= 1'b1;
    @(posedge sys_clk_in);
    soft_reset_in <= 1'b0;
    repeat (3) @(negedge sys_clk_in);
    cmp({tx, pd}, 3'h0);
    cmp({media, mac}, {clamp(sv[7:5]), clamp(sv[4:2])});
    go(0, `EPR_IDX_PAGE, 0);
    cmp(r, `EPR_PAGE_MAIN);
    @(posedge sys_clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    @(negedge sys_clk_in);
    cmp({tx, pd, media, mac}, {6'h0, `EPR_RST_MAC_SW});
    wrap_up();
  end
endmodule
